// [hw/spm_power_ctrl.sv]
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/10ps
// Behaviour
// - global mode field 00 normal, 01 energy detect, 10 soft down, 11 saving
// - port control bit 3 set powers that PHY port down regardless of mode
// - mode field resets to normal; clocks, PHY, MAC and host all on
// - from normal or saving, a new mode value moves directly there
// - saving entered only with field 11, autoneg on, cable unplugged
// - saving keeps PLL, MAC, registers, host, transmitter; receiver idle off
// - in saving, returning line activity restores full PHY power
// - energy detect has normal and low power states; traffic only in normal
// - sleep after no energy longer than the eight-bit sleep delay
// - low power state keeps only the host interface, receiver energy detector and port PHY enables alive
// - energy seen in low power state returns to normal power state
// - energy detect without link emits 120 ns pulses once per second
// - soft power down stops PLL, PHY and MAC, keeps register values
// - writing 00 leaves soft power down back to normal operation
// - global register bit 2 disables the PLL in energy detect mode
module spm_power_ctrl #(
    parameter int unsigned SLEEP_TICK   = spm_pkg::SLEEP_TICK_CY,
    parameter int unsigned PULSE_PERIOD = spm_pkg::PULSE_PERIOD_CY
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // line status
    input  wire logic        cable_energy,
    input  wire logic        link_up,
    // power controls
    output logic             pll_enable,
    output logic             mac_enable,
    output logic             host_enable,
    output logic             phy_tx_enable,
    output logic             phy_rx_enable,
    output logic             rx_energy_det_enable,
    output logic             packet_enable,
    output logic [1:0]       port_phy_enable,
    output logic             line_pulse
);
    import spm_pkg::*;

    // ---------------------------------------------------------------
    // reset synchroniser
    // ---------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic [2:0] decode_addr(input logic [7:0] adr);
        unique case (adr)
            ADDR_PORT1_PHY_CONTROL:   decode_addr = 3'(REG_PORT1);
            ADDR_PORT2_PHY_CONTROL:   decode_addr = 3'(REG_PORT2);
            ADDR_GLOBAL_POWER_MODE:   decode_addr = 3'(REG_GMODE);
            ADDR_SLEEP_DELAY_SETTING: decode_addr = 3'(REG_SLEEP);
            ADDR_LINE_STATUS:         decode_addr = 3'(REG_LINE);
            ADDR_POWER_STATUS:        decode_addr = 3'(REG_PSTAT);
            ADDR_PORT_STATUS:         decode_addr = 3'(REG_PORTST);
            default:                  decode_addr = 3'(NUM_REGS);
        endcase
    endfunction : decode_addr

    // ---------------------------------------------------------------
    // register file and bus slave
    // ---------------------------------------------------------------
    logic [7:0]  port_ctrl [NUM_PORTS];
    logic [7:0]  next_port_ctrl [NUM_PORTS];
    logic [7:0]  gmode;
    logic [7:0]  sleep_delay;
    logic [7:0]  line_cfg;
    logic [7:0]  next_gmode;
    logic [7:0]  next_sleep_delay;
    logic [7:0]  next_line_cfg;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        next_err;
    logic [2:0]  sel_reg;
    logic        wr_go;
    logic        rd_go;
    logic        req;
    logic [7:0]  pstat;
    logic [7:0]  portst;

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign sel_reg = decode_addr(wb_adr_i);
    assign wr_go   = req && wb_we_i && wb_sel_i[0] && (sel_reg != 3'(NUM_REGS));
    assign rd_go   = req && !wb_we_i && (sel_reg != 3'(NUM_REGS));

    // writes, read mux and answer one cycle after the request
    always_comb begin
        next_gmode       = gmode;
        next_sleep_delay = sleep_delay;
        next_line_cfg    = line_cfg;
        next_port_ctrl   = port_ctrl;
        next_dat         = 32'h0;
        next_ack         = req && (sel_reg != 3'(NUM_REGS));
        next_err         = req && (sel_reg == 3'(NUM_REGS));
        if (wr_go) begin
            unique case (sel_reg)
                3'(REG_PORT1): next_port_ctrl[0] = wb_dat_i[7:0];
                3'(REG_PORT2): next_port_ctrl[1] = wb_dat_i[7:0];
                3'(REG_GMODE): next_gmode        = wb_dat_i[7:0];
                3'(REG_SLEEP): next_sleep_delay  = wb_dat_i[7:0];
                3'(REG_LINE):  next_line_cfg     = wb_dat_i[7:0];
                default:       next_gmode        = gmode;
            endcase
        end
        if (rd_go) begin
            unique case (sel_reg)
                3'(REG_PORT1):  next_dat = {24'h0, port_ctrl[0]};
                3'(REG_PORT2):  next_dat = {24'h0, port_ctrl[1]};
                3'(REG_GMODE):  next_dat = {24'h0, gmode};
                3'(REG_SLEEP):  next_dat = {24'h0, sleep_delay};
                3'(REG_LINE):   next_dat = {24'h0, line_cfg};
                3'(REG_PSTAT):  next_dat = {24'h0, pstat};
                3'(REG_PORTST): next_dat = {24'h0, portst};
                default:        next_dat = 32'h0;
            endcase
        end
    end

    // register state; all contents kept through every mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gmode        <= RST_GMODE;
            sleep_delay  <= RST_SLEEP;
            line_cfg     <= RST_LINE;
            port_ctrl[0] <= RST_PORT_CTRL;
            port_ctrl[1] <= RST_PORT_CTRL;
            wb_dat_o     <= 32'h0;
            wb_ack_o     <= 1'b0;
            wb_err_o     <= 1'b0;
        end else begin
            gmode        <= next_gmode;
            sleep_delay  <= next_sleep_delay;
            line_cfg     <= next_line_cfg;
            port_ctrl[0] <= next_port_ctrl[0];
            port_ctrl[1] <= next_port_ctrl[1];
            wb_dat_o     <= next_dat;
            wb_ack_o     <= next_ack;
            wb_err_o     <= next_err;
        end
    end

    // ---------------------------------------------------------------
    // mode selection and energy detect state machine
    // ---------------------------------------------------------------
    typedef enum logic {
        SPM_ED_AWAKE,
        SPM_ED_ASLEEP
    } spm_ed_e;

    spm_mode_e  field_mode;
    spm_ed_e    ed_state;
    spm_ed_e    next_ed_state;
    logic [8:0] idle_ticks;
    logic [8:0] next_idle_ticks;
    logic       sleep_tick;
    logic       saving_active;
    logic       autoneg_on;

    assign field_mode = spm_mode_e'(gmode[1:0]);
    assign autoneg_on = line_cfg[POS_LINE_AUTONEG];
    // saving applies only while unplugged; activity wakes it at once
    assign saving_active = (field_mode == SPM_MODE_PSAVE) && autoneg_on
                           && !cable_energy && !link_up;

    spm_tick_div #(
        .PERIOD (SLEEP_TICK)
    ) u_sleep_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (cable_energy),
        .tick    (sleep_tick)
    );

    // idle time in ticks; sleeping once it exceeds the delay
    always_comb begin
        next_ed_state   = ed_state;
        next_idle_ticks = idle_ticks;
        if (field_mode != SPM_MODE_ENERGY) begin
            next_ed_state   = SPM_ED_AWAKE;
            next_idle_ticks = 9'h0;
        end else if (cable_energy) begin
            next_ed_state   = SPM_ED_AWAKE;
            next_idle_ticks = 9'h0;
        end else begin
            unique case (ed_state)
                SPM_ED_AWAKE: begin
                    if (sleep_tick) begin
                        next_idle_ticks = idle_ticks + 9'h1;
                    end
                    if (idle_ticks > {1'b0, sleep_delay}) begin
                        next_ed_state = SPM_ED_ASLEEP;
                    end
                end
                SPM_ED_ASLEEP: next_idle_ticks = idle_ticks;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ed_state   <= SPM_ED_AWAKE;
            idle_ticks <= 9'h0;
        end else begin
            ed_state   <= next_ed_state;
            idle_ticks <= next_idle_ticks;
        end
    end

    // ---------------------------------------------------------------
    // one-second line pulse in energy detect mode without link
    // ---------------------------------------------------------------
    logic [31:0] pulse_cnt;
    logic [31:0] next_pulse_cnt;
    logic        next_line_pulse;
    logic        pulse_on;

    assign pulse_on = (field_mode == SPM_MODE_ENERGY) && !link_up;

    // a started pulse always runs to full width, even if the link comes up
    always_comb begin
        next_pulse_cnt  = 32'h0;
        next_line_pulse = 1'b0;
        if (pulse_on || line_pulse) begin
            next_pulse_cnt = (pulse_cnt == 32'(PULSE_PERIOD - 1)) ? 32'h0
                             : pulse_cnt + 32'h1;
            next_line_pulse = pulse_cnt < 32'(PULSE_CYCLES);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pulse_cnt  <= 32'h0;
            line_pulse <= 1'b0;
        end else begin
            pulse_cnt  <= next_pulse_cnt;
            line_pulse <= next_line_pulse;
        end
    end

    // ---------------------------------------------------------------
    // power enables
    // ---------------------------------------------------------------
    logic       next_pll;
    logic       next_mac;
    logic       next_host;
    logic       next_tx;
    logic       next_rx;
    logic       next_edet;
    logic       next_pkt;
    logic [1:0] next_port_en;
    logic       asleep;

    assign asleep = (ed_state == SPM_ED_ASLEEP);
    assign pstat  = {5'h0, saving_active, asleep, ed_state == SPM_ED_AWAKE};
    assign portst = {6'h0, port_phy_enable};

    always_comb begin
        next_pll  = 1'b1;
        next_mac  = 1'b1;
        next_host = 1'b1;
        next_tx   = 1'b1;
        next_rx   = 1'b1;
        next_edet = 1'b1;
        next_pkt  = 1'b1;
        unique case (field_mode)
            SPM_MODE_NORMAL: next_pkt = 1'b1;
            SPM_MODE_PSAVE: next_rx = !saving_active;
            SPM_MODE_ENERGY: begin
                next_pll  = !gmode[POS_PLL_DISABLE] && !asleep;
                next_mac  = !asleep;
                next_tx   = !asleep;
                next_rx   = !asleep;
                next_pkt  = !asleep;
                next_host = 1'b1;
            end
            SPM_MODE_SOFTPD: begin
                next_pll  = 1'b0;
                next_mac  = 1'b0;
                next_tx   = 1'b0;
                next_rx   = 1'b0;
                next_edet = 1'b0;
                next_pkt  = 1'b0;
                next_host = 1'b1;
            end
        endcase
    end

    // per-port power down mask
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        assign next_port_en[p] = !port_ctrl[p][POS_PORT_PWRDN]
                                 && (next_tx || next_rx || next_edet);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_enable           <= 1'b1;
            mac_enable           <= 1'b1;
            host_enable          <= 1'b1;
            phy_tx_enable        <= 1'b1;
            phy_rx_enable        <= 1'b1;
            rx_energy_det_enable <= 1'b1;
            packet_enable        <= 1'b1;
            port_phy_enable      <= 2'h3;
        end else begin
            pll_enable           <= next_pll;
            mac_enable           <= next_mac;
            host_enable          <= next_host;
            phy_tx_enable        <= next_tx;
            phy_rx_enable        <= next_rx;
            rx_energy_det_enable <= next_edet;
            packet_enable        <= next_pkt;
            port_phy_enable      <= next_port_en;
        end
    end
endmodule : spm_power_ctrl

// [hw/spm_pkg.sv]
package spm_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses, each register eight bits in byte lane 0)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT1_PHY_CONTROL   = 8'h1d;
    localparam logic [7:0] ADDR_PORT2_PHY_CONTROL   = 8'h2d;
    localparam logic [7:0] ADDR_GLOBAL_POWER_MODE   = 8'hc3;
    localparam logic [7:0] ADDR_SLEEP_DELAY_SETTING = 8'hc4;
    localparam logic [7:0] ADDR_LINE_STATUS         = 8'hc8;
    localparam logic [7:0] ADDR_POWER_STATUS        = 8'hcc;
    localparam logic [7:0] ADDR_PORT_STATUS         = 8'hd0;

    localparam int unsigned REG_PORT1  = 0;
    localparam int unsigned REG_PORT2  = 1;
    localparam int unsigned REG_GMODE  = 2;
    localparam int unsigned REG_SLEEP  = 3;
    localparam int unsigned REG_LINE   = 4;
    localparam int unsigned REG_PSTAT  = 5;
    localparam int unsigned REG_PORTST = 6;
    localparam int unsigned NUM_REGS   = 7;

    // ---------------------------------------------------------------
    // field layout and reset values
    // ---------------------------------------------------------------
    localparam int unsigned POS_PORT_PWRDN   = 3;
    localparam int unsigned POS_PLL_DISABLE  = 2;
    localparam int unsigned POS_LINE_AUTONEG = 0;
    localparam logic [7:0]  RST_PORT_CTRL    = 8'h00;
    localparam logic [7:0]  RST_GMODE        = 8'h00;
    localparam logic [7:0]  RST_SLEEP        = 8'h00;
    localparam logic [7:0]  RST_LINE         = 8'h01;
    localparam int unsigned NUM_PORTS        = 2;

    typedef enum logic [1:0] {
        SPM_MODE_NORMAL  = 2'h0,
        SPM_MODE_ENERGY  = 2'h1,
        SPM_MODE_SOFTPD  = 2'h2,
        SPM_MODE_PSAVE   = 2'h3
    } spm_mode_e;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    localparam int unsigned PULSE_WIDTH_NS  = 120;
    localparam int unsigned PULSE_CYCLES    = PULSE_WIDTH_NS / CLK_PERIOD_NS;
    localparam int unsigned PULSE_PERIOD_S  = 1;
    localparam int unsigned PULSE_PERIOD_CY = PULSE_PERIOD_S * CLK_HZ;
    localparam int unsigned SLEEP_TICK_MS   = 1;
    localparam int unsigned SLEEP_TICK_CY   = SLEEP_TICK_MS * (CLK_HZ / 1000);
endpackage : spm_pkg

// [hw/spm_tick_div.sv]
`timescale 1ns/10ps
// ---------------------------------------------------------------
// free-running divider giving a one-cycle enable every PERIOD clocks
// ---------------------------------------------------------------
module spm_tick_div #(
    parameter int unsigned PERIOD = 50_000
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      tick
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_tick;

    // count down, restart on clear
    always_comb begin
        next_count = count - 32'h1;
        next_tick  = 1'b0;
        if (clear) begin
            next_count = 32'(PERIOD - 1);
        end else if (count == 32'h0) begin
            next_count = 32'(PERIOD - 1);
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= 32'h0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule : spm_tick_div

// [tb/spm_power_ctrl_sva.sv]
`timescale 1ns/10ps
// --------
// port checker of the power controller
// --------
module spm_power_ctrl_sva (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        cable_energy,
    input wire logic        link_up,
    input wire logic        pll_enable,
    input wire logic        mac_enable,
    input wire logic        host_enable,
    input wire logic        phy_tx_enable,
    input wire logic        phy_rx_enable,
    input wire logic        rx_energy_det_enable,
    input wire logic        packet_enable,
    input wire logic [1:0]  port_phy_enable,
    input wire logic        line_pulse
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // low power state: transmitter off, energy detector alive
    logic asleep;
    assign asleep = !phy_tx_enable && rx_energy_det_enable;
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    sequence answer_s;
        ##1 (wb_ack_o ^ wb_err_o);
    endsequence
    sequence burst_s;
        line_pulse [*6] ##1 !line_pulse;
    endsequence
    bus_answer_a: assert property (req_s |-> answer_s)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_data_a: assert property (wb_err_o |-> wb_dat_o == 32'h0 && !wb_ack_o)
        else $error("refused access with data or ack");
    host_on_a: assert property (host_enable)
        else $error("host interface switched off");
    pulse_width_a: assert property ($rose(line_pulse) |-> burst_s)
        else $error("line pulse not six cycles wide");
    pulse_gap_a: assert property ($fell(line_pulse) |-> !line_pulse [*8])
        else $error("line pulses too close");
    pulse_nolink_a: assert property ($rose(line_pulse) |-> !$past(link_up))
        else $error("line pulse with link up");
    sleep_quiet_a: assert property (asleep |-> !packet_enable && !mac_enable
        && !phy_rx_enable && !pll_enable)
        else $error("circuitry alive in low power state");
    wake_up_a: assert property (asleep && cable_energy |-> ##[1:2] packet_enable)
        else $error("no wake on cable energy");
    stay_awake_a: assert property (cable_energy |-> ##2 !asleep [*2])
        else $error("slept while energy seen");
endmodule : spm_power_ctrl_sva

bind spm_power_ctrl spm_power_ctrl_sva u_sva (
    .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .cable_energy(cable_energy), .link_up(link_up), .pll_enable(pll_enable),
    .mac_enable(mac_enable), .host_enable(host_enable), .phy_tx_enable(phy_tx_enable),
    .phy_rx_enable(phy_rx_enable), .rx_energy_det_enable(rx_energy_det_enable),
    .packet_enable(packet_enable), .port_phy_enable(port_phy_enable),
    .line_pulse(line_pulse));

// [tb/spm_link_partner.sv]
`timescale 1ns/10ps
// --------
// far end: energy follows the plug, link after a short training
// --------
module spm_link_partner #(
    parameter int unsigned LINK_DELAY = 3
) (
    input  wire logic clk_sys,
    input  wire logic plugged,
    input  wire logic far_link,
    output logic      cable_energy,
    output logic      link_up
);
    logic [3:0] train_cnt = 4'h0;
    initial begin
        cable_energy = 1'b0;
        link_up = 1'b0;
    end
    // line state changes just after the clock edge
    always @(posedge clk_sys) begin
        cable_energy <= plugged;
        if (!(plugged && far_link)) begin
            train_cnt <= 4'h0;
        end else if (train_cnt != 4'(LINK_DELAY)) begin
            train_cnt <= train_cnt + 4'h1;
        end
        link_up <= plugged && far_link && (train_cnt == 4'(LINK_DELAY));
    end
endmodule : spm_link_partner

// [tb/test_switch_power_mode_control.sv]
`timescale 1ns/10ps
module test_switch_power_mode_control;
    import spm_pkg::*;
    localparam int unsigned TICK = 4;
    localparam int unsigned PER  = 40;
    logic        clk_sys  = 1'b0;
    logic        nrst     = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i  = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        plugged  = 1'b0;
    logic        far_link = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, wb_err_o, cable_energy, link_up, line_pulse;
    logic        pll_enable, mac_enable, host_enable, phy_tx_enable;
    logic        phy_rx_enable, rx_energy_det_enable, packet_enable;
    logic [1:0]  port_phy_enable;
    logic [31:0] rd;
    logic        er;
    int          err_total = 0;
    int          checks = 0;
    int          n;
    logic [7:0]  adrs [5] = '{ADDR_PORT1_PHY_CONTROL, ADDR_PORT2_PHY_CONTROL,
                              ADDR_GLOBAL_POWER_MODE, ADDR_SLEEP_DELAY_SETTING, ADDR_LINE_STATUS};
    logic [7:0]  rsts [5] = '{RST_PORT_CTRL, RST_PORT_CTRL, RST_GMODE, RST_SLEEP, RST_LINE};

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    spm_power_ctrl #(.SLEEP_TICK(TICK), .PULSE_PERIOD(PER)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .cable_energy(cable_energy), .link_up(link_up), .pll_enable(pll_enable),
        .mac_enable(mac_enable), .host_enable(host_enable), .phy_tx_enable(phy_tx_enable),
        .phy_rx_enable(phy_rx_enable), .rx_energy_det_enable(rx_energy_det_enable),
        .packet_enable(packet_enable), .port_phy_enable(port_phy_enable),
        .line_pulse(line_pulse));
    spm_link_partner u_far (.clk_sys(clk_sys), .plugged(plugged), .far_link(far_link),
        .cable_energy(cable_energy), .link_up(link_up));

    // --------
    // shared tasks
    // --------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    // one classic cycle, held until ack or err is sampled
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       input logic [3:0] sel);
        int k;
        k = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 50);
        if (k >= 50) begin
            check("bus answer", 0, 1);
            print_verdict();
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        bus(1'b1, adr, {24'h0, d}, 4'hf);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 32'h0, 4'hf);
        check(what, rd, {24'h0, exp});
    endtask : rdc
    // enables in order pll, mac, host, tx, rx, packet
    task automatic en(input string what, input logic [5:0] exp);
        repeat (4) @(posedge clk_sys);
        check(what, {pll_enable, mac_enable, host_enable, phy_tx_enable, phy_rx_enable,
                     packet_enable}, exp);
    endtask : en
    task automatic pulses;
        n = 0;
        repeat (8) @(posedge clk_sys);
        repeat (80) begin
            @(posedge clk_sys);
            if (line_pulse === 1'b1) n++;
        end
    endtask : pulses

    // --------
    // test sequence
    // --------
    initial begin
        repeat (8) @(posedge clk_sys);
        en("reset enables", 6'b111111);
        check("reset ports", port_phy_enable, 2'b11);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 5; i++) rdc("reset value", adrs[i], rsts[i]);
        bus(1'b0, 8'h10, 32'h0, 4'hf);
        check("unmapped err", er, 1'b1);
        bus(1'b1, ADDR_SLEEP_DELAY_SETTING, 32'h33, 4'he);
        rdc("masked write", ADDR_SLEEP_DELAY_SETTING, 8'h00);
        wr(ADDR_SLEEP_DELAY_SETTING, 8'ha5);
        rdc("sleep delay", ADDR_SLEEP_DELAY_SETTING, 8'ha5);
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_GLOBAL_POWER_MODE, 8'(m));
            rdc("mode code", ADDR_GLOBAL_POWER_MODE, 8'(m));
        end
        $display("test registers done");
        wr(ADDR_SLEEP_DELAY_SETTING, 8'h02);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h02);
        en("soft down", 6'b001000);
        check("detector off", rx_energy_det_enable, 1'b0);
        rdc("kept in down", ADDR_SLEEP_DELAY_SETTING, 8'h02);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h00);
        en("down to normal", 6'b111111);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h03);
        en("saving idle", 6'b111101);
        plugged <= 1'b1;
        en("saving active", 6'b111111);
        plugged <= 1'b0;
        wr(ADDR_LINE_STATUS, 8'h00);
        en("saving no autoneg", 6'b111111);
        wr(ADDR_LINE_STATUS, 8'h01);
        en("saving again", 6'b111101);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h02);
        en("saving to down", 6'b001000);
        $display("test modes done");
        plugged <= 1'b1;
        wr(ADDR_GLOBAL_POWER_MODE, 8'h01);
        en("energy awake", 6'b111111);
        @(posedge clk_sys);
        plugged <= 1'b0;
        n = 0;
        while (!(phy_tx_enable === 1'b0 && rx_energy_det_enable === 1'b1) && n < 60) begin
            @(posedge clk_sys);
            n++;
        end
        check("sleep not early", n > 2 * TICK, 1'b1);
        check("sleep in time", n <= 6 * TICK, 1'b1);
        en("low power", 6'b001000);
        check("detector on", rx_energy_det_enable, 1'b1);
        rdc("power status", ADDR_POWER_STATUS, 8'h02);
        pulses();
        check("pulse cycles", n, 12);
        plugged <= 1'b1;
        en("energy wake", 6'b111111);
        check("woken", packet_enable, 1'b1);
        plugged <= 1'b0;
        repeat (8) @(posedge clk_sys);
        plugged <= 1'b1;
        @(posedge clk_sys);
        plugged <= 1'b0;
        repeat (9) @(posedge clk_sys);
        check("idle restart", packet_enable, 1'b1);
        plugged <= 1'b1;
        far_link <= 1'b1;
        wr(ADDR_GLOBAL_POWER_MODE, 8'h05);
        en("pll off", 6'b011111);
        pulses();
        check("pulses with link", n, 0);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h04);
        en("pll bit outside energy", 6'b111111);
        far_link <= 1'b0;
        $display("test energy done");
        wr(ADDR_PORT1_PHY_CONTROL, 8'h08);
        en("port one down", 6'b111111);
        check("port one off", port_phy_enable, 2'b10);
        wr(ADDR_PORT2_PHY_CONTROL, 8'h08);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h03);
        en("ports in saving", 6'b111111);
        check("both ports off", port_phy_enable, 2'b00);
        rdc("port status", ADDR_PORT_STATUS, 8'h00);
        wr(ADDR_PORT1_PHY_CONTROL, 8'h00);
        wr(ADDR_PORT2_PHY_CONTROL, 8'h00);
        wr(ADDR_GLOBAL_POWER_MODE, 8'h00);
        en("ports back", 6'b111111);
        check("ports on", port_phy_enable, 2'b11);
        $display("test ports done");
        print_verdict();
    end
endmodule : test_switch_power_mode_control
